// >>> hw/ldc_config_bank.sv
// Purpose: Per-unit configuration banks behind index and data ports
// Assumes: Port strobes are one-cycle pulses in sys_clk domain
// Notes:   Chip-level registers other than unit select left out
`timescale 1ns/10ps
`default_nettype none
module ldc_config_bank (
    input  wire logic                        sys_clk,
    input  wire logic                        reset_n,
    input  wire logic                        configOpen,
    input  wire logic                        indexWrite,
    input  wire logic                        dataWrite,
    input  wire logic                        dataRead,
    input  wire logic [7:0]                  hostWriteData,
    input  wire logic [ldc_pkg::NUM_UNITS-1:0] powerSet,
    input  wire logic [ldc_pkg::NUM_UNITS-1:0] powerClear,
    output logic [7:0]                       hostReadData,
    output logic                             readValid,
    output logic [ldc_pkg::NUM_UNITS-1:0]    unitOn,
    output logic [ldc_pkg::NUM_UNITS-1:0]    unitDecodeEn,
    output logic [ldc_pkg::NUM_UNITS-1:0]    irqEdgeHigh,
    output logic [7:0]                       unitSelect
);
    import ldc_pkg::*;
    logic [7:0]           regIndex;
    logic [7:0]           bankRead [NUM_UNITS];
    logic [NUM_UNITS-1:0] bankOn, bankValid;
    logic [7:0]           next_readData;
    logic                 inRange;

    assign inRange = unitSelect < 8'(NUM_UNITS);

    // Index and unit select accepted only while config state open
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            regIndex   <= 8'h00;
            unitSelect <= RESET_UNIT_SELECT;
        end else if (configOpen) begin
            if (indexWrite) regIndex <= hostWriteData;
            else if (dataWrite && regIndex == IDX_UNIT_SELECT)
                unitSelect <= hostWriteData;
        end
    end

    genvar u;
    generate
        for (u = 0; u < NUM_UNITS; u++) begin : g_unit
            localparam logic [3:0] ID = 4'(u);
            ldc_unit_bank #(
                .HAS_BASE  (ID == UNIT_FLOPPY || ID == UNIT_PARALLEL ||
                            ID == UNIT_SERIAL1 || ID == UNIT_SERIAL2),
                .HAS_BASE2 (ID == UNIT_SERIAL2),
                .HAS_IRQ2  (ID == UNIT_KEYBOARD),
                .HAS_DMA   (ID == UNIT_FLOPPY || ID == UNIT_SERIAL2 || ID == UNIT_PARALLEL),
                .ALIGN4_OK (ID == UNIT_PARALLEL)
            ) bank (
                .sys_clk    (sys_clk),
                .reset_n    (reset_n),
                // Only the bank selected at write time is touched
                .writeEn    (configOpen && dataWrite && unitSelect == 8'(u)),
                .regIndex   (regIndex),
                .writeData  (hostWriteData),
                .powerSet   (powerSet[u]),
                .powerClear (powerClear[u]),
                .readData   (bankRead[u]),
                .unitOn     (bankOn[u]),
                .baseValid  (bankValid[u]),
                .ioBase     (),
                .ioBase2    ()
            );
        end
    endgenerate

    always_comb begin
        next_readData = 8'h00;
        if (regIndex == IDX_UNIT_SELECT) next_readData = unitSelect;
        else if (inRange) next_readData = bankRead[unitSelect[3:0]];
    end

    // Read answer registered so outputs come from flops
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            hostReadData <= 8'h00;
            readValid    <= 1'b0;
        end else begin
            readValid    <= configOpen && dataRead;
            hostReadData <= (configOpen && dataRead) ? next_readData : 8'h00;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            unitOn       <= '0;
            unitDecodeEn <= '0;
            irqEdgeHigh  <= {NUM_UNITS{IRQ_EDGE_HIGH}};
        end else begin
            unitOn       <= bankOn;
            unitDecodeEn <= bankOn & bankValid;
            irqEdgeHigh  <= {NUM_UNITS{IRQ_EDGE_HIGH}};
        end
    end
endmodule
`default_nettype wire

// >>> hw/ldc_pkg.sv
// Purpose: Constants for the per-unit configuration register banks
// Assumes: Host reaches banks through an index/data port pair
// Notes:   Summary of rules below
//
// Summary of operation
// - One register bank per unit, chosen by select
// - Index port picks register, data port accesses it
// - Bank access only while configuration state open
// - Activate bit 0 turns selected unit on
// - Control to memory base range reads zero
// - Primary base: high byte then low byte
// - Second base pair holds high then low
// - Unused base registers ignore writes, read zero
// - Primary interrupt select everywhere, reset zero
// - Secondary interrupt select only in keyboard unit
// - Interrupts default to active-high edge
// - Unimplemented locations ignore writes, read zero
// - DMA select in floppy, serial two, parallel
// - Second DMA select never implemented
// - Unit on when activate or power bit set
// - Activate and power bits move together
// - Out-of-range base makes unit accesses invalid
// - Base decode uses address bits 11..0 only
package ldc_pkg;
    localparam int          NUM_UNITS          = 10;
    localparam logic [7:0] IDX_UNIT_SELECT    = 8'h07;
    localparam logic [7:0] IDX_ACTIVATE       = 8'h30;
    localparam logic [7:0] IDX_IO_BASE_HIGH   = 8'h60;
    localparam logic [7:0] IDX_IO_BASE_LOW    = 8'h61;
    localparam logic [7:0] IDX_IO2_BASE_HIGH  = 8'h62;
    localparam logic [7:0] IDX_IO2_BASE_LOW   = 8'h63;
    localparam logic [7:0] IDX_IRQ_PRIMARY    = 8'h70;
    localparam logic [7:0] IDX_IRQ_SECONDARY  = 8'h72;
    localparam logic [7:0] IDX_DMA_SELECT     = 8'h74;
    localparam int          ACTIVATE_BIT       = 0;
    localparam logic [7:0] RESET_ACTIVATE     = 8'h00;
    localparam logic [7:0] RESET_BASE         = 8'h00;
    localparam logic [7:0] RESET_IRQ          = 8'h00;
    localparam logic [7:0] RESET_DMA          = 8'h04;
    localparam logic [7:0] RESET_UNIT_SELECT  = 8'h00;
    localparam logic [3:0] UNIT_FLOPPY        = 4'h0;
    localparam logic [3:0] UNIT_PARALLEL      = 4'h3;
    localparam logic [3:0] UNIT_SERIAL1       = 4'h4;
    localparam logic [3:0] UNIT_SERIAL2       = 4'h5;
    localparam logic [3:0] UNIT_KEYBOARD      = 4'h7;
    localparam logic [11:0] BASE_MIN          = 12'h100;
    localparam logic [11:0] BASE_MAX8         = 12'hff8;
    localparam logic [11:0] BASE_MAX4         = 12'hffc;
    localparam logic       IRQ_EDGE_HIGH      = 1'b1;
endpackage

// >>> hw/ldc_unit_bank.sv
// Purpose: One unit's configuration registers
// Assumes: Writes qualified by caller with this unit selected
// Notes:   Unused locations read zero per unit flags
`timescale 1ns/10ps
`default_nettype none
module ldc_unit_bank #(
    parameter bit HAS_BASE   = 1'b1,
    parameter bit HAS_BASE2  = 1'b0,
    parameter bit HAS_IRQ2   = 1'b0,
    parameter bit HAS_DMA    = 1'b0,
    parameter bit ALIGN4_OK  = 1'b0
) (
    input  wire logic        sys_clk,
    input  wire logic        reset_n,
    input  wire logic        writeEn,
    input  wire logic [7:0]  regIndex,
    input  wire logic [7:0]  writeData,
    input  wire logic        powerSet,
    input  wire logic        powerClear,
    output logic [7:0]       readData,
    output logic             unitOn,
    output logic             baseValid,
    output logic [15:0]      ioBase,
    output logic [15:0]      ioBase2
);
    import ldc_pkg::*;
    logic       activate;
    logic [7:0] baseHigh, baseLow, base2High, base2Low, irq1, irq2, dma;
    logic [11:0] dec;

    // Power bit shares the activate flop so both always agree
    always_ff @(posedge sys_clk) begin
        if (!reset_n) activate <= RESET_ACTIVATE[ACTIVATE_BIT];
        else if (writeEn && regIndex == IDX_ACTIVATE) activate <= writeData[ACTIVATE_BIT];
        else if (powerSet) activate <= 1'b1;
        else if (powerClear) activate <= 1'b0;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            baseHigh  <= RESET_BASE;
            baseLow   <= RESET_BASE;
            base2High <= RESET_BASE;
            base2Low  <= RESET_BASE;
            irq1      <= RESET_IRQ;
            irq2      <= RESET_IRQ;
            dma       <= RESET_DMA;
        end else if (writeEn) begin
            case (regIndex)
                IDX_IO_BASE_HIGH:  if (HAS_BASE) baseHigh <= writeData;
                IDX_IO_BASE_LOW:   if (HAS_BASE) baseLow <= writeData;
                IDX_IO2_BASE_HIGH: if (HAS_BASE2) base2High <= writeData;
                IDX_IO2_BASE_LOW:  if (HAS_BASE2) base2Low <= writeData;
                IDX_IRQ_PRIMARY:   irq1 <= writeData;
                IDX_IRQ_SECONDARY: if (HAS_IRQ2) irq2 <= writeData;
                IDX_DMA_SELECT:    if (HAS_DMA) dma <= writeData;
                default: ;
            endcase
        end
    end

    always_comb begin
        case (regIndex)
            IDX_ACTIVATE:      readData = {7'h00, activate};
            IDX_IO_BASE_HIGH:  readData = HAS_BASE ? baseHigh : 8'h00;
            IDX_IO_BASE_LOW:   readData = HAS_BASE ? baseLow : 8'h00;
            IDX_IO2_BASE_HIGH: readData = HAS_BASE2 ? base2High : 8'h00;
            IDX_IO2_BASE_LOW:  readData = HAS_BASE2 ? base2Low : 8'h00;
            IDX_IRQ_PRIMARY:   readData = irq1;
            IDX_IRQ_SECONDARY: readData = HAS_IRQ2 ? irq2 : 8'h00;
            IDX_DMA_SELECT:    readData = HAS_DMA ? dma : 8'h00;
            default:           readData = 8'h00;
        endcase
    end

    assign dec    = {baseHigh[3:0], baseLow};
    assign unitOn = activate;
    assign ioBase  = HAS_BASE ? {baseHigh, baseLow} : 16'h0000;
    assign ioBase2 = HAS_BASE2 ? {base2High, base2Low} : 16'h0000;
    // Out-of-range base blocks the unit's own port decode
    assign baseValid = !HAS_BASE ? 1'b1 :
        (dec >= BASE_MIN) && (ALIGN4_OK ? (dec <= BASE_MAX4 && dec[1:0] == 2'b00)
                                        : (dec <= BASE_MAX8 && dec[2:0] == 3'b000));
endmodule
`default_nettype wire

// >>> tb/ldc_config_bank_assertions.sv
// Purpose: Port checks of the unit banks
// Assumes: One clock, synchronous reset
// Notes:   Unit 0 stands for all units in the power checks
`timescale 1ns/10ps
`default_nettype none
module ldc_config_bank_assertions (
    input wire logic                          sys_clk,
    input wire logic                          reset_n,
    input wire logic                          configOpen,
    input wire logic                          indexWrite,
    input wire logic                          dataWrite,
    input wire logic                          dataRead,
    input wire logic [7:0]                    hostWriteData,
    input wire logic [ldc_pkg::NUM_UNITS-1:0] powerSet,
    input wire logic [ldc_pkg::NUM_UNITS-1:0] powerClear,
    input wire logic [7:0]                    hostReadData,
    input wire logic                          readValid,
    input wire logic [ldc_pkg::NUM_UNITS-1:0] unitOn,
    input wire logic [ldc_pkg::NUM_UNITS-1:0] unitDecodeEn,
    input wire logic [ldc_pkg::NUM_UNITS-1:0] irqEdgeHigh,
    input wire logic [7:0]                    unitSelect
);
    import ldc_pkg::*;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence rd_taken;
        dataRead && configOpen;
    endsequence
    sequence quiet;
        !configOpen && powerSet == '0 && powerClear == '0;
    endsequence
    // Unit outputs trail a write by two edges, so wait two quiet cycles
    sequence settled;
        quiet ##1 quiet;
    endsequence
    read_answer_a: assert property (rd_taken |=> readValid)
        else $error("read got no answer");
    closed_read_a: assert property (!configOpen && dataRead |=> !readValid)
        else $error("read answered while closed");
    no_spurious_a: assert property (readValid |-> $past(dataRead && configOpen))
        else $error("answer without a read");
    closed_hold_a: assert property (settled |=> $stable(unitOn) && $stable(unitSelect))
        else $error("state moved while closed");
    irq_edge_a: assert property (irqEdgeHigh == '1)
        else $error("interrupt not edge high");
    power_on_a: assert property (powerSet[0] && !dataWrite |-> ##[1:2] unitOn[0])
        else $error("unit 0 did not power on");
    power_off_a: assert property (powerClear[0] && !dataWrite |-> ##[1:2] !unitOn[0])
        else $error("unit 0 did not power off");
    decode_gate_a: assert property ((unitDecodeEn & ~unitOn) == '0)
        else $error("decode on inactive unit");
    plain_decode_a: assert property (unitDecodeEn[1] == unitOn[1])
        else $error("baseless unit decode differs from on");
endmodule
bind ldc_config_bank ldc_config_bank_assertions u_chk (
    .sys_clk, .reset_n, .configOpen, .indexWrite, .dataWrite, .dataRead, .hostWriteData,
    .powerSet, .powerClear, .hostReadData, .readValid, .unitOn, .unitDecodeEn,
    .irqEdgeHigh, .unitSelect);
`default_nettype wire

// >>> tb/ldc_host_model.sv
// Purpose: Host driving index and data ports
// Assumes: Strobes one cycle, set at falling edge
// Notes:   Idle data bus shows inverse of last value
`timescale 1ns/10ps
`default_nettype none
module ldc_host_model (
    input  wire logic       sys_clk,
    input  wire logic       readValid,
    input  wire logic [7:0] hostReadData,
    output logic            configOpen,
    output logic            indexWrite,
    output logic            dataWrite,
    output logic            dataRead,
    output logic [7:0]      hostWriteData
);
    initial {configOpen, indexWrite, dataWrite, dataRead, hostWriteData} = '0;
    task automatic open_cfg(input logic b);
        @(negedge sys_clk);
        configOpen = b;
    endtask
    task automatic pulse(input logic [2:0] s, input logic [7:0] d);
        @(negedge sys_clk);
        {indexWrite, dataWrite, dataRead} = s;
        hostWriteData = d;
        @(negedge sys_clk);
        {indexWrite, dataWrite, dataRead} = 3'h0;
        hostWriteData = ~d;
    endtask
    task automatic wr(input logic [7:0] i, input logic [7:0] d);
        pulse(3'h4, i);
        pulse(3'h2, d);
    endtask
    task automatic rd(input logic [7:0] i, output logic [7:0] d, output bit ok);
        pulse(3'h4, i);
        pulse(3'h1, 8'h00);
        ok = readValid;
        d = hostReadData;
    endtask
endmodule
`default_nettype wire

// >>> tb/test_logical_device_config_bank.sv
// Purpose: Self-checking bench for the unit banks
// Assumes: Host model owns the port strobes
// Notes:   Bank contents modelled as integers
`timescale 1ns/10ps
`default_nettype none
module test_logical_device_config_bank;
    import ldc_pkg::*;
    logic                 sys_clk = 1'b0;
    logic                 reset_n = 1'b0;
    logic                 configOpen, indexWrite, dataWrite, dataRead, readValid;
    logic [7:0]           hostWriteData, hostReadData, unitSelect;
    logic [NUM_UNITS-1:0] powerSet = '0, powerClear = '0, unitOn, unitDecodeEn, irqEdgeHigh;
    int                   err_count = 0, checked = 0, seed = 9204, sel, u, k;
    int                   mdl [16][256];
    int                   idx [20] = '{'h30, 'h31, 'h3f, 'h40, 'h5f, 'h60, 'h61, 'h62, 'h63,
        'h6f, 'h70, 'h71, 'h72, 'h73, 'h74, 'h75, 'h76, 'ha8, 'ha9, 'hdf};
    always #5 sys_clk = ~sys_clk;
    ldc_config_bank u_dut (.sys_clk, .reset_n, .configOpen, .indexWrite, .dataWrite, .dataRead,
        .hostWriteData, .powerSet, .powerClear, .hostReadData, .readValid, .unitOn,
        .unitDecodeEn, .irqEdgeHigh, .unitSelect);
    ldc_host_model u_host (.sys_clk, .readValid, .hostReadData, .configOpen, .indexWrite,
        .dataWrite, .dataRead, .hostWriteData);
    task automatic close_out;
        if (err_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %0t byte %h not %h", $time, g, e);
        end
    endtask
    task automatic cmp_vec(input logic [NUM_UNITS-1:0] g, input logic [NUM_UNITS-1:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %0t units %b not %b", $time, g, e);
        end
    endtask
    function automatic bit impl(int b, int i);
        return b < NUM_UNITS && (i inside {'h30, 'h70} || (b inside {0, 3, 4, 5} && i inside
            {'h60, 'h61}) || (b == 5 && i inside {'h62, 'h63}) || (b == 7 && i == 'h72) ||
            (b inside {0, 3, 5} && i == 'h74));
    endfunction
    function automatic bit dec(int b);
        int a = (mdl[b]['h60] * 256 + mdl[b]['h61]) % 4096;
        // Parallel unit may sit on a 4-byte step, the rest on 8
        return mdl[b]['h30] % 2 == 1 && (!(b inside {0, 3, 4, 5}) ||
            (a >= 'h100 && a % (b == 3 ? 4 : 8) == 0));
    endfunction
    task automatic vchk;
        logic [NUM_UNITS-1:0] on, de;
        @(negedge sys_clk);
        for (int b = 0; b < NUM_UNITS; b++) begin
            on[b] = mdl[b]['h30] % 2;
            de[b] = dec(b);
        end
        cmp_vec(unitOn, on);
        cmp_vec(unitDecodeEn, de);
        cmp_byte(unitSelect, 8'(sel));
    endtask
    task automatic wchk(input int i, input int d);
        u_host.wr(8'(i), 8'(d));
        if (configOpen && i == 7) sel = d;
        else if (configOpen && impl(sel, i)) mdl[sel][i] = d;
        vchk();
    endtask
    task automatic rchk(input int i);
        logic [7:0] d;
        bit         ok;
        u_host.rd(8'(i), d, ok);
        cmp_byte({7'h0, ok}, {7'h0, configOpen});
        if (ok) cmp_byte(d, i == 7 ? 8'(sel) : impl(sel, i) ? 8'(mdl[sel][i]) : 8'h00);
    endtask
    task automatic pwr(input int b, input bit on);
        @(negedge sys_clk);
        if (on) powerSet[b] = 1'b1;
        else powerClear[b] = 1'b1;
        @(negedge sys_clk);
        powerSet = '0;
        powerClear = '0;
        mdl[b]['h30] = on;
        vchk();
        if (b == sel) rchk('h30);
    endtask
    task automatic mreset;
        sel = 0;
        foreach (mdl[b, i]) mdl[b][i] = i == 'h74 ? 4 : 0;
    endtask
    initial begin
        repeat (100000) @(posedge sys_clk);
        err_count++;
        close_out();
    end
    initial begin
        mreset();
        repeat (8) @(posedge sys_clk);
        @(negedge sys_clk) reset_n = 1'b1;
        u_host.open_cfg(1'b1);
        cmp_vec(irqEdgeHigh, '1);
        for (u = 0; u < 11; u++) begin
            wchk(7, u);
            foreach (idx[j]) rchk(idx[j]);
        end
        repeat (300) begin
            wchk(7, $unsigned($random(seed)) % 11);
            k = idx[$unsigned($random(seed)) % 20];
            u = $random(seed) & 'hff;
            // Low base bytes kept aligned, primary high byte random, second high byte odd; activate bit only
            u = k == 'h30 ? u % 2 : k == 'h62 ? u | 1 : u;
            if (k inside {'h61, 'h63}) u = u & (k == 'h61 && sel == 3 ? 'hfc : 'hf8);
            wchk(k, u);
            rchk(k);
        end
        u_host.open_cfg(1'b0);
        wchk(7, 2);
        wchk('h30, 1);
        rchk('h30);
        u_host.open_cfg(1'b1);
        for (u = 0; u < NUM_UNITS; u++) begin
            pwr(u, 1'b1);
            pwr(u, 1'b0);
        end
        wchk('h30, 1);
        @(negedge sys_clk) reset_n = 1'b0;
        repeat (2) @(negedge sys_clk);
        reset_n = 1'b1;
        mreset();
        vchk();
        cmp_vec(irqEdgeHigh, '1);
        rchk('h70);
        rchk('h74);
        close_out();
    end
endmodule
`default_nettype wire
